// [rtl/xqfr_defines.vh]
// result codes, request encodings and defaults for the translation query fault resolver
`ifndef XQFR_DEFINES_VH
`define XQFR_DEFINES_VH

// ----------------------------------------------------------------
// query result codes
// ----------------------------------------------------------------
`define XQFR_CODE_SUCCESS          8'h00
`define XQFR_CODE_MALFORMED        8'hff
`define XQFR_CODE_ABSENT_STAGE     8'hfe
`define XQFR_CODE_INTERNAL         8'hfd
`define XQFR_CODE_SID_RANGE        8'h02
`define XQFR_CODE_ENTRY_FETCH      8'h03
`define XQFR_CODE_BAD_ENTRY        8'h04
`define XQFR_CODE_STREAM_DISABLED  8'h06
`define XQFR_CODE_SSID_RANGE       8'h08
`define XQFR_CODE_CTX_FETCH        8'h09
`define XQFR_CODE_BAD_CTX          8'h0a
`define XQFR_CODE_WALK_ABORT       8'h0b
`define XQFR_CODE_TRANSLATION      8'h10
`define XQFR_CODE_ADDR_SIZE        8'h11
`define XQFR_CODE_ACCESS_FLAG      8'h12
`define XQFR_CODE_PERMISSION       8'h13
`define XQFR_CODE_LOOKUP_CONFLICT  8'h20
`define XQFR_CODE_CONFIG_CONFLICT  8'h21
`define XQFR_CODE_VMS_FETCH        8'h25

// ----------------------------------------------------------------
// request type encodings
// ----------------------------------------------------------------
`define XQFR_TYPE_NONE             2'h0
`define XQFR_TYPE_STAGE1           2'h1
`define XQFR_TYPE_STAGE2           2'h2
`define XQFR_TYPE_BOTH             2'h3

// ----------------------------------------------------------------
// default substream settings
// ----------------------------------------------------------------
`define XQFR_DSS_TERMINATE         2'h0
`define XQFR_DSS_SUBSTREAM0        2'h2

// ----------------------------------------------------------------
// stream entry configuration field positions
// ----------------------------------------------------------------
`define XQFR_CFG_STAGE1_BIT        0
`define XQFR_CFG_STAGE2_BIT        1
`define XQFR_CFG_TRANSLATE_BIT     2

// ----------------------------------------------------------------
// default widths
// ----------------------------------------------------------------
`define XQFR_SID_W                 24
`define XQFR_SSID_W                20
`define XQFR_VMID_W                16

`endif

// [rtl/xqfr_resolver.v]
// fault priority and result code resolver for software translation queries
`timescale 1ns/1ps
`include "xqfr_defines.vh"

module xqfr_resolver #(
  parameter SID_W  = `XQFR_SID_W,
  parameter SSID_W = `XQFR_SSID_W,
  parameter VMID_W = `XQFR_VMID_W
) (
  input  wire              mclk,
  input  wire              rst,
  // query request
  input  wire              queryStart,
  input  wire [1:0]        queryType,
  input  wire              vmRestricted,
  input  wire [VMID_W-1:0] interfaceVmSelector,
  input  wire              querySecure,
  input  wire              secureStreamSelect,
  input  wire              secureStage2Capable,
  input  wire              globalEnable,
  input  wire              unitError,
  input  wire [SID_W-1:0]  queryStreamId,
  input  wire [5:0]        streamTableLog2,
  input  wire              querySubstreamValid,
  input  wire [SSID_W-1:0] querySubstreamId,
  // stream table entry fetch
  input  wire              entryRsp,
  input  wire              entryAbort,
  input  wire              entryValid,
  input  wire [2:0]        entryConfig,
  input  wire [4:0]        contextTableLimit,
  input  wire [1:0]        defaultSubstreamSetting,
  input  wire              entryVmTagged,
  input  wire [VMID_W-1:0] entryVmTag,
  input  wire              entrySecure,
  input  wire              entryNeedsVms,
  // virtual machine structure fetch
  input  wire              vmsRsp,
  input  wire              vmsAbort,
  // context descriptor fetch
  input  wire              ctxRsp,
  input  wire              ctxAbort,
  input  wire              ctxStage2Fault,
  input  wire [1:0]        ctxFaultKind,
  input  wire              ctxValid,
  // table walk
  input  wire              walkRsp,
  input  wire              walkAbort,
  input  wire              walkStage2Fault,
  input  wire              walkFault,
  input  wire [1:0]        walkFaultKind,
  input  wire              lookupConflict,
  input  wire              configConflict,
  // results and fetch requests
  output reg               busy_q,
  output reg               done_q,
  output reg               queryFaultFlag_q,
  output reg  [7:0]        queryResultCode_q,
  output reg               entryFetchReq_q,
  output reg               vmsFetchReq_q,
  output reg               ctxFetchReq_q,
  output reg               walkReq_q
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ENTRY = 3'h1;
  localparam [2:0] ST_VMS   = 3'h2;
  localparam [2:0] ST_CHECK = 3'h3;
  localparam [2:0] ST_CTX   = 3'h4;
  localparam [2:0] ST_WALK  = 3'h5;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // ids wider than the port are already truncated, so only the table size matters
  function outOfRange;
    input [31:0] id;
    input [5:0]  log2Size;
    begin
      if (log2Size >= 6'h20) begin
        outOfRange = 1'b0;
      end else begin
        outOfRange = (id >> log2Size) != 32'h0;
      end
    end
  endfunction

  function [7:0] faultClassCode;
    input [1:0] kind;
    begin
      faultClassCode = `XQFR_CODE_TRANSLATION + {6'h0, kind};
    end
  endfunction

  // ----------------------------------------------------------------
  // state and captured request
  // ----------------------------------------------------------------
  reg [2:0]        state_q;
  reg [2:0]        state_d;
  reg [1:0]        type_q;
  reg              vmIf_q;
  reg              ssv_q;
  reg [SSID_W-1:0] ssid_q;
  reg [2:0]        cfg_q;
  reg [4:0]        ctxLimit_q;
  reg [1:0]        dss_q;
  reg              busy_d;
  reg              done_d;
  reg              fault_d;
  reg [7:0]        code_d;
  reg              entryReq_d;
  reg              vmsReq_d;
  reg              ctxReq_d;
  reg              walkReq_d;
  reg              endNow;
  reg [7:0]        endCode;

  wire [31:0]       sidWide  = {{(32-SID_W){1'b0}}, queryStreamId};
  wire [31:0]       ssidWide = {{(32-SSID_W){1'b0}}, ssid_q};
  wire              internalStop = unitError | ~globalEnable;
  wire              stage1Only = (type_q == `XQFR_TYPE_STAGE1);
  wire              cfgS1 = cfg_q[`XQFR_CFG_STAGE1_BIT];
  wire              cfgS2 = cfg_q[`XQFR_CFG_STAGE2_BIT];
  wire              cfgOn = cfg_q[`XQFR_CFG_TRANSLATE_BIT];

  // a vm-restricted interface only answers stage 1 queries
  wire              malformed = (queryType == `XQFR_TYPE_NONE) |
                                (vmRestricted & (queryType != `XQFR_TYPE_STAGE1));
  // without secure stage 2 a secure stream can never serve a stage 2 query
  wire              staticAbsent = querySecure & secureStreamSelect & ~secureStage2Capable &
                                   queryType[1];
  wire [VMID_W-1:0] effectiveVm = (entrySecure & ~entryConfig[`XQFR_CFG_STAGE2_BIT]) ?
                                  {VMID_W{1'b0}} : entryVmTag;
  wire              vmDenied = vmIf_q & (~entryVmTagged | (effectiveVm != interfaceVmSelector));
  wire              lateAbsent = ~cfgOn | (type_q[1] & ~cfgS2) | (type_q[0] & vmIf_q & ~cfgS1);
  wire              ctxPresent = cfgS1 & (ctxLimit_q != 5'h0);
  wire              ssidBad = ssv_q & cfgS1 & outOfRange(ssidWide, ctxLimit_q);
  wire              streamOff = ctxPresent &
                                ((~ssv_q & (dss_q == `XQFR_DSS_TERMINATE)) |
                                 (ssv_q & (ssid_q == {SSID_W{1'b0}}) & (dss_q == `XQFR_DSS_SUBSTREAM0)));

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always @* begin
    state_d    = state_q;
    busy_d     = busy_q;
    done_d     = 1'b0;
    fault_d    = queryFaultFlag_q;
    code_d     = queryResultCode_q;
    entryReq_d = 1'b0;
    vmsReq_d   = 1'b0;
    ctxReq_d   = 1'b0;
    walkReq_d  = 1'b0;
    endNow     = 1'b0;
    endCode    = `XQFR_CODE_SUCCESS;
    case (state_q)
      ST_IDLE: begin
        // a start while busy is ignored, the idle state alone accepts one
        if (queryStart) begin
          busy_d = 1'b1;
          if (malformed) begin
            endNow  = 1'b1;
            endCode = `XQFR_CODE_MALFORMED;
          end else if (staticAbsent) begin
            endNow  = 1'b1;
            endCode = `XQFR_CODE_ABSENT_STAGE;
          end else if (internalStop) begin
            endNow  = 1'b1;
            endCode = `XQFR_CODE_INTERNAL;
          end else if (outOfRange(sidWide, streamTableLog2)) begin
            endNow  = 1'b1;
            endCode = `XQFR_CODE_SID_RANGE;
          end else begin
            entryReq_d = 1'b1;
            state_d    = ST_ENTRY;
          end
        end
      end
      ST_ENTRY: begin
        if (internalStop) begin
          endNow  = 1'b1;
          endCode = `XQFR_CODE_INTERNAL;
        end else if (entryRsp) begin
          if (entryAbort) begin
            endNow  = 1'b1;
            endCode = `XQFR_CODE_ENTRY_FETCH;
          end else if (~entryValid) begin
            endNow  = 1'b1;
            endCode = `XQFR_CODE_BAD_ENTRY;
          end else if (vmDenied) begin
            endNow  = 1'b1;
            endCode = `XQFR_CODE_BAD_ENTRY;
          end else if (entryNeedsVms) begin
            vmsReq_d = 1'b1;
            state_d  = ST_VMS;
          end else begin
            state_d = ST_CHECK;
          end
        end
      end
      ST_VMS: begin
        if (internalStop) begin
          endNow  = 1'b1;
          endCode = `XQFR_CODE_INTERNAL;
        end else if (vmsRsp) begin
          if (vmsAbort) begin
            endNow  = 1'b1;
            endCode = `XQFR_CODE_VMS_FETCH;
          end else begin
            state_d = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        if (internalStop) begin
          endNow  = 1'b1;
          endCode = `XQFR_CODE_INTERNAL;
        end else if (lateAbsent) begin
          endNow  = 1'b1;
          endCode = `XQFR_CODE_ABSENT_STAGE;
        end else if (ssidBad) begin
          endNow  = 1'b1;
          endCode = `XQFR_CODE_SSID_RANGE;
        end else if (streamOff) begin
          endNow  = 1'b1;
          endCode = `XQFR_CODE_STREAM_DISABLED;
        end else if (cfgS1 & type_q[0]) begin
          ctxReq_d = 1'b1;
          state_d  = ST_CTX;
        end else begin
          walkReq_d = 1'b1;
          state_d   = ST_WALK;
        end
      end
      ST_CTX: begin
        if (internalStop) begin
          endNow  = 1'b1;
          endCode = `XQFR_CODE_INTERNAL;
        end else if (ctxRsp) begin
          if (ctxStage2Fault) begin
            endNow  = 1'b1;
            endCode = stage1Only ? `XQFR_CODE_CTX_FETCH : faultClassCode(ctxFaultKind);
          end else if (ctxAbort) begin
            endNow  = 1'b1;
            endCode = `XQFR_CODE_CTX_FETCH;
          end else if (~ctxValid) begin
            endNow  = 1'b1;
            endCode = `XQFR_CODE_BAD_CTX;
          end else begin
            walkReq_d = 1'b1;
            state_d   = ST_WALK;
          end
        end
      end
      ST_WALK: begin
        if (internalStop) begin
          endNow  = 1'b1;
          endCode = `XQFR_CODE_INTERNAL;
        end else if (walkRsp) begin
          endNow = 1'b1;
          if (walkAbort | (walkStage2Fault & stage1Only)) begin
            endCode = `XQFR_CODE_WALK_ABORT;
          end else if (lookupConflict) begin
            endCode = `XQFR_CODE_LOOKUP_CONFLICT;
          end else if (configConflict) begin
            endCode = `XQFR_CODE_CONFIG_CONFLICT;
          end else if (walkFault | walkStage2Fault) begin
            endCode = faultClassCode(walkFaultKind);
          end else begin
            endCode = `XQFR_CODE_SUCCESS;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        busy_d  = 1'b0;
      end
    endcase
    // the first fault found ends the query, so later checks never overwrite it
    if (endNow) begin
      state_d = ST_IDLE;
      busy_d  = 1'b0;
      done_d  = 1'b1;
      code_d  = endCode;
      fault_d = (endCode != `XQFR_CODE_SUCCESS);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      state_q           <= ST_IDLE;
      busy_q            <= 1'b0;
      done_q            <= 1'b0;
      queryFaultFlag_q  <= 1'b0;
      queryResultCode_q <= `XQFR_CODE_SUCCESS;
      entryFetchReq_q   <= 1'b0;
      vmsFetchReq_q     <= 1'b0;
      ctxFetchReq_q     <= 1'b0;
      walkReq_q         <= 1'b0;
      type_q            <= `XQFR_TYPE_NONE;
      vmIf_q            <= 1'b0;
      ssv_q             <= 1'b0;
      ssid_q            <= {SSID_W{1'b0}};
      cfg_q             <= 3'h0;
      ctxLimit_q        <= 5'h0;
      dss_q             <= 2'h0;
    end else begin
      state_q           <= state_d;
      busy_q            <= busy_d;
      done_q            <= done_d;
      queryFaultFlag_q  <= fault_d;
      queryResultCode_q <= code_d;
      entryFetchReq_q   <= entryReq_d;
      vmsFetchReq_q     <= vmsReq_d;
      ctxFetchReq_q     <= ctxReq_d;
      walkReq_q         <= walkReq_d;
      // type, vm restriction and substream fields are frozen at start; interfaceVmSelector is still read live at the entry response
      if (state_q == ST_IDLE && queryStart) begin
        type_q <= queryType;
        vmIf_q <= vmRestricted;
        ssv_q  <= querySubstreamValid;
        ssid_q <= querySubstreamId;
      end
      if (state_q == ST_ENTRY && entryRsp) begin
        cfg_q      <= entryConfig;
        ctxLimit_q <= contextTableLimit;
        dss_q      <= defaultSubstreamSetting;
      end
    end
  end

endmodule

// [verif/xqfr_chk.sv]
// concurrent checks on the query fault resolver ports
`timescale 1ns/1ps
module xqfr_chk (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       queryStart,
  input wire logic [1:0] queryType,
  input wire logic       vmRestricted,
  input wire logic       querySecure,
  input wire logic       globalEnable,
  input wire logic       unitError,
  input wire logic [5:0] streamTableLog2,
  input wire logic       entryRsp,
  input wire logic       entryAbort,
  input wire logic       vmsRsp,
  input wire logic       vmsAbort,
  input wire logic       ctxRsp,
  input wire logic       ctxAbort,
  input wire logic       ctxStage2Fault,
  input wire logic       ctxValid,
  input wire logic       walkRsp,
  input wire logic       walkAbort,
  input wire logic       walkStage2Fault,
  input wire logic       lookupConflict,
  input wire logic       busy_q,
  input wire logic       done_q,
  input wire logic       queryFaultFlag_q,
  input wire logic [7:0] queryResultCode_q,
  input wire logic       entryFetchReq_q,
  input wire logic       vmsFetchReq_q,
  input wire logic       ctxFetchReq_q,
  input wire logic       walkReq_q
);
  logic [3:0] wait_q;
  // a query ended by an internal stop leaves no wait behind it
  wire  [3:0] waiting = (done_q ? 4'h0 : wait_q) | {walkReq_q, ctxFetchReq_q, vmsFetchReq_q, entryFetchReq_q};
  wire        allOk   = globalEnable & ~unitError;
  // the vm-restricted interface only takes stage 1 queries
  wire        badType = (queryType == 2'h0) | (vmRestricted & (queryType != 2'h1));

  // ----------------------------------------
  // wait tracking
  // ----------------------------------------
  // responses outside a wait state are ignored, so only judge them inside one
  always @(posedge mclk) begin
    wait_q <= (rst | done_q) ? 4'h0 : waiting & ~{walkRsp, ctxRsp, vmsRsp, entryRsp};
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence sStart;
    queryStart && !busy_q;
  endsequence
  sequence sEnd(logic [7:0] c);
    done_q && queryResultCode_q == c;
  endsequence

  a_malformed_static: assert property (sStart ##0 badType |=> sEnd(8'hff))
    else $error("malformed query not answered at once");
  a_internal_static: assert property (sStart ##0 (!badType && !querySecure && !allOk) |=> sEnd(8'hfd))
    else $error("internal stop not reported");
  a_entry_first: assert property (sStart ##0 (!badType && !querySecure && allOk && streamTableLog2 >= 6'h20)
    |=> entryFetchReq_q && busy_q)
    else $error("entry fetch not issued after start");
  a_entry_abort: assert property (waiting[0] && entryRsp && entryAbort && allOk |=> sEnd(8'h03))
    else $error("entry abort code wrong");
  a_vms_abort: assert property (waiting[1] && vmsRsp && vmsAbort && allOk |=> sEnd(8'h25))
    else $error("vm structure abort code wrong");
  a_ctx_invalid: assert property (waiting[2] && ctxRsp && !ctxAbort && !ctxStage2Fault && !ctxValid && allOk
    |=> sEnd(8'h0a))
    else $error("bad context code wrong");
  a_walk_lookup: assert property (waiting[3] && walkRsp && !walkAbort && !walkStage2Fault && lookupConflict && allOk
    |=> sEnd(8'h20))
    else $error("lookup conflict code wrong");
  a_flag_code: assert property (done_q |-> queryFaultFlag_q == (queryResultCode_q != 8'h00))
    else $error("fault flag disagrees with code");
  a_code_listed: assert property (done_q |-> queryResultCode_q inside {8'h00, 8'hff, 8'hfe, 8'hfd, 8'h02, 8'h03,
    8'h04, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21, 8'h25})
    else $error("reserved result code");
  a_req_busy: assert property ((entryFetchReq_q || vmsFetchReq_q || ctxFetchReq_q || walkReq_q)
    |-> busy_q && $onehot({walkReq_q, ctxFetchReq_q, vmsFetchReq_q, entryFetchReq_q}))
    else $error("fetch request outside a running query");
endmodule

bind xqfr_resolver xqfr_chk u_xqfr_chk (.*);

// [verif/tb.sv]
// self-checking bench for the query fault resolver
`timescale 1ns/1ps
`include "xqfr_defines.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic queryStart, vmRestricted, querySecure, secureStreamSelect, secureStage2Capable;
  logic globalEnable, unitError, querySubstreamValid, entryAbort, entryValid, entryVmTagged;
  logic entrySecure, entryNeedsVms, vmsAbort, ctxAbort, ctxStage2Fault, ctxValid;
  logic walkAbort, walkStage2Fault, walkFault, lookupConflict, configConflict;
  logic entryRsp = 1'b0, vmsRsp = 1'b0, ctxRsp = 1'b0, walkRsp = 1'b0;
  logic [1:0] queryType, defaultSubstreamSetting, ctxFaultKind, walkFaultKind;
  logic [2:0] entryConfig;
  logic [4:0] contextTableLimit;
  logic [5:0] streamTableLog2;
  logic [15:0] interfaceVmSelector, entryVmTag;
  logic [19:0] querySubstreamId;
  logic [23:0] queryStreamId;
  logic busy_q, done_q, queryFaultFlag_q, entryFetchReq_q, vmsFetchReq_q, ctxFetchReq_q, walkReq_q;
  logic [7:0] queryResultCode_q, expCode;
  logic [3:0] dly_q = 4'h0;
  logic [7:0] expQ[$];
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  xqfr_resolver u_xqfr_resolver (.*);

  initial forever #5 mclk = ~mclk;

  // ----------------------------------------
  // far side answers each fetch two cycles late
  // ----------------------------------------
  always @(negedge mclk) begin
    dly_q <= {walkReq_q, ctxFetchReq_q, vmsFetchReq_q, entryFetchReq_q};
    {walkRsp, ctxRsp, vmsRsp, entryRsp} <= dly_q;
  end

  always @(negedge mclk) begin
    if (done_q === 1'b1) begin
      if (expQ.size() == 0) begin
        err_total++;
        $display("BAD done exp none got pulse");
      end else begin
        expCode = expQ.pop_front();
        `CHK("code", expCode, queryResultCode_q)
        `CHK("flag", expCode != 8'h00, queryFaultFlag_q)
        `CHK("busy", 1'b0, busy_q)
      end
    end
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      $display("BAD timeout exp done got none");
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // clean stage 1 query on a translating stage 1 stream
  task automatic dflt();
    {queryStart, vmRestricted, interfaceVmSelector, querySecure, secureStreamSelect, unitError,
     querySubstreamValid, querySubstreamId, entryAbort, contextTableLimit, defaultSubstreamSetting,
     entryVmTag, entrySecure, entryNeedsVms, vmsAbort, ctxAbort, ctxStage2Fault, ctxFaultKind,
     walkAbort, walkStage2Fault, walkFault, walkFaultKind, lookupConflict, configConflict} = '0;
    {entryValid, ctxValid, globalEnable, secureStage2Capable, entryVmTagged} = 5'h1f;
    queryType = `XQFR_TYPE_STAGE1;
    entryConfig = 3'h5;
    streamTableLog2 = 6'h20;
    queryStreamId = 24'($urandom());
  endtask

  task automatic q(input logic [7:0] e);
    expQ.push_back(e);
    queryStart = 1'b1;
    @(negedge mclk);
    queryStart = 1'b0;
    while (done_q !== 1'b1) @(negedge mclk);
    // let an edge pass so the next start never rewrites the strobe in this step
    @(negedge mclk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(60742));
    dflt();
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    {queryType, vmRestricted} = 3'h1;
    {querySecure, secureStreamSelect, secureStage2Capable, globalEnable} = 4'hc;
    q(`XQFR_CODE_MALFORMED);
    {queryType, vmRestricted} = 3'h4;
    q(`XQFR_CODE_ABSENT_STAGE);
    dflt();
    globalEnable = 1'b0;
    q(`XQFR_CODE_INTERNAL);
    {unitError, globalEnable, streamTableLog2} = 8'hc4;
    queryStreamId = 24'h10;
    q(`XQFR_CODE_INTERNAL);
    unitError = 1'b0;
    q(`XQFR_CODE_SID_RANGE);
    queryStreamId = 24'hf;
    q(`XQFR_CODE_SUCCESS);
    $display("test static done");
    dflt();
    {entryValid, entryAbort} = 2'h1;
    q(`XQFR_CODE_ENTRY_FETCH);
    {entryAbort, entryNeedsVms, vmsAbort} = 3'h3;
    q(`XQFR_CODE_BAD_ENTRY);
    {entryValid, entryConfig} = 4'h9;
    q(`XQFR_CODE_VMS_FETCH);
    vmsAbort = 1'b0;
    q(`XQFR_CODE_ABSENT_STAGE);
    dflt();
    queryType = `XQFR_TYPE_STAGE2;
    q(`XQFR_CODE_ABSENT_STAGE);
    $display("test entry done");
    dflt();
    vmRestricted = 1'b1;
    interfaceVmSelector = 16'($urandom());
    entryVmTag = interfaceVmSelector ^ 16'h1;
    q(`XQFR_CODE_BAD_ENTRY);
    {entryVmTag, entryVmTagged} = {interfaceVmSelector, 1'b0};
    q(`XQFR_CODE_BAD_ENTRY);
    entryVmTagged = 1'b1;
    q(`XQFR_CODE_SUCCESS);
    entryConfig = 3'h6;
    q(`XQFR_CODE_ABSENT_STAGE);
    {entryConfig, entrySecure, interfaceVmSelector} = {3'h5, 1'b1, 16'h0};
    q(`XQFR_CODE_SUCCESS);
    $display("test vm done");
    dflt();
    {entryConfig, querySubstreamValid, querySubstreamId, contextTableLimit} = {3'h1, 1'b1, 20'h4, 5'h2};
    q(`XQFR_CODE_ABSENT_STAGE);
    entryConfig = 3'h5;
    q(`XQFR_CODE_SSID_RANGE);
    querySubstreamId = 20'h3;
    q(`XQFR_CODE_SUCCESS);
    {querySubstreamId, defaultSubstreamSetting} = {20'h0, `XQFR_DSS_SUBSTREAM0};
    q(`XQFR_CODE_STREAM_DISABLED);
    {querySubstreamValid, defaultSubstreamSetting} = {1'b0, `XQFR_DSS_TERMINATE};
    q(`XQFR_CODE_STREAM_DISABLED);
    contextTableLimit = 5'h0;
    q(`XQFR_CODE_SUCCESS);
    $display("test substream done");
    dflt();
    {ctxStage2Fault, ctxAbort, ctxValid} = 3'h6;
    q(`XQFR_CODE_CTX_FETCH);
    {queryType, entryConfig, ctxFaultKind} = {`XQFR_TYPE_BOTH, 3'h7, 2'h2};
    q(`XQFR_CODE_ACCESS_FLAG);
    ctxStage2Fault = 1'b0;
    q(`XQFR_CODE_CTX_FETCH);
    ctxAbort = 1'b0;
    q(`XQFR_CODE_BAD_CTX);
    $display("test context done");
    dflt();
    {walkAbort, lookupConflict, walkFault} = 3'h7;
    q(`XQFR_CODE_WALK_ABORT);
    {walkAbort, walkStage2Fault, configConflict} = 3'h3;
    q(`XQFR_CODE_WALK_ABORT);
    walkStage2Fault = 1'b0;
    q(`XQFR_CODE_LOOKUP_CONFLICT);
    lookupConflict = 1'b0;
    q(`XQFR_CODE_CONFIG_CONFLICT);
    configConflict = 1'b0;
    for (int k = 0; k < 4; k++) begin
      walkFaultKind = 2'(k);
      q(`XQFR_CODE_TRANSLATION + 8'(k));
    end
    {queryType, entryConfig, walkStage2Fault} = {`XQFR_TYPE_BOTH, 3'h7, 1'b1};
    q(`XQFR_CODE_PERMISSION);
    $display("test walk done");
    repeat (3) @(negedge mclk);
    stop_test();
  end
endmodule
